// ==== common/aerc_defs.svh ====
// Register offsets, field positions and reset values of the converter event and result registers.
`ifndef AERC_DEFS_SVH
`define AERC_DEFS_SVH
`define AERC_OFF_MASKED_STATUS 8'h30
`define AERC_OFF_EVENT_MASK 8'h34
`define AERC_OFF_RAW_STATUS 8'h38
`define AERC_OFF_EVENT_CLEAR 8'h3C
`define AERC_OFF_FINAL_RESULT 8'h44
`define AERC_OFF_UNCAL_RESULT 8'h48
`define AERC_OFF_OFFSET_CAL 8'h4C
`define AERC_OFF_GAIN_CAL 8'h50
`define AERC_OFF_TEST_CTRL 8'h54
`define AERC_OFF_AUDIO_CTRL 8'h58
`define AERC_NUM_EVENTS 7
`define AERC_EVT_RESET 7'h00
`define AERC_MASK_RESET 7'h7F
`define AERC_RAW_W 22
`define AERC_CAL_W 16
`define AERC_USR_LSB 16
`define AERC_TEST_EN_BIT 0
`define AERC_TEST_SEL_LSB 1
`define AERC_TEST_SEL_W 3
`define AERC_AUD_EN_BIT 0
`define AERC_AUD_GAIN_LSB 3
`define AERC_AUD_GAIN_W 3
`define AERC_AUD_CM_LSB 6
`define AERC_AUD_CM_W 3
`define AERC_AUD_CHOP_BIT 9
`define AERC_CM_RESET 3'h4
`define AERC_CHOP_RESET 1'h1
`define AERC_GAIN_RESET 3'h0
`define AERC_ZERO32 32'h0000_0000
`define AERC_GAIN_VAL_RESET 6'h04
`define AERC_CAL_RESET 16'h0000
`define AERC_ROUTE_RESET 8'h00
`define AERC_DRIVE_N_RESET 1'h1
`endif

// ==== common/aerc_pkg.sv ====
// Types shared by the converter event and result register block.
package aerc_pkg;
  typedef struct packed {
    logic [2:0] preamp_common_mode;
    logic [2:0] preamp_gain;
    logic chop_en;
    logic audio_en;
  } aerc_audio_t;

  typedef struct packed {
    logic [2:0] sel;
    logic en;
  } aerc_test_t;

  typedef enum logic [1:0] {
    AERC_IDLE,
    AERC_ACK
  } aerc_bus_state_t;
endpackage

// ==== hw/aerc_audio_decode.sv ====
// Decode of the audio preamp and analog test controls into analog-facing signals.
`timescale 1ns/100ps
`include "aerc_defs.svh"
module aerc_audio_decode (
  // Controls
  input wire aerc_pkg::aerc_audio_t audio_i,
  input wire aerc_pkg::aerc_test_t test_i,
  // Decoded
  output logic [5:0] preamp_gain_value_o,
  output logic [7:0] test_route_o,
  output logic test_drive_n_o
);
  always_comb
  begin
    case (audio_i.preamp_gain)
      3'h0: preamp_gain_value_o = 6'h04;
      3'h1: preamp_gain_value_o = 6'h08;
      3'h2: preamp_gain_value_o = 6'h10;
      3'h3: preamp_gain_value_o = 6'h20;
      default: preamp_gain_value_o = 6'h04;
    endcase
  end

  // Output enable is low while the test pin is driven.
  always_comb
  begin
    test_route_o = 8'h00;
    test_drive_n_o = 1'b1;
    if (test_i.en)
    begin
      test_route_o[test_i.sel] = 1'b1;
      test_drive_n_o = 1'b0;
    end
  end
endmodule

// ==== hw/aerc_event_flags.sv ====
// Sticky raw event flags with write-one-to-clear and masked view.
`timescale 1ns/100ps
`include "aerc_defs.svh"
module aerc_event_flags (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Events and clears
  input wire logic [6:0] event_i,
  input wire logic [6:0] clear_i,
  input wire logic [6:0] mask_i,
  // Status
  output logic [6:0] raw_o,
  output logic [6:0] masked_o
);
  logic [6:0] raw_q;

  genvar g;
  generate
    for (g = 0; g < `AERC_NUM_EVENTS; g = g + 1)
    begin : gen_flag
      // A new event wins over a clear in the same cycle so it is never lost.
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          raw_q[g] <= 1'b0;
        else if (event_i[g])
          raw_q[g] <= 1'b1;
        else if (clear_i[g])
          raw_q[g] <= 1'b0;
        else
          raw_q[g] <= raw_q[g];
      end
    end
  endgenerate

  assign raw_o = raw_q;
  assign masked_o = raw_q & ~mask_i;

  flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(raw_q[0]) |-> $past(clear_i[0]))
    else $error("raw flag cleared without a clear request");
  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    event_i[3] |=> raw_q[3])
    else $error("event did not set raw flag");
  flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (clear_i[5] && !event_i[5]) |=> !raw_q[5])
    else $error("clear did not clear raw flag");
  flag_cover_c: cover property (@(posedge clk_i) disable iff (rst_i)
    raw_q[0] ##1 !raw_q[0]);
endmodule

// ==== hw/aerc_regs.sv ====
// Wishbone register bank for converter events, results, calibration, test and audio control.
`timescale 1ns/100ps
`include "aerc_defs.svh"
module aerc_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Converter side
  input wire logic [6:0] event_i,
  input wire logic [31:0] final_result_i,
  input wire logic [21:0] raw_result_i,
  input wire logic [15:0] self_offset_i,
  input wire logic [15:0] self_gain_i,
  // Calibration and analog controls
  output logic [15:0] user_offset_o,
  output logic [15:0] user_gain_o,
  output logic audio_en_o,
  output logic decim_en_o,
  output logic chop_en_o,
  output logic [2:0] preamp_common_mode_o,
  output logic [5:0] preamp_gain_value_o,
  output logic [7:0] test_route_o,
  output logic test_drive_n_o,
  // Interrupt
  output logic irq_o
);
  //////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  aerc_pkg::aerc_bus_state_t state_q;
  logic req;
  logic wr_hit;
  logic [31:0] rd_d;
  logic [6:0] mask_q;
  logic [6:0] clear_d;
  logic [6:0] raw;
  logic [6:0] masked;
  logic [15:0] user_offset_q;
  logic [15:0] user_gain_q;
  aerc_pkg::aerc_audio_t audio_q;
  aerc_pkg::aerc_test_t test_q;
  logic [5:0] gain_val;
  logic [7:0] route;
  logic drive_n;

  assign req = wb_cyc_i && wb_stb_i && (state_q == aerc_pkg::AERC_IDLE);
  assign wr_hit = req && wb_we_i;

  // One registered answer per request, a cycle after it; ack drops the cycle after it rises.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_q <= aerc_pkg::AERC_IDLE;
    else
    begin
      case (state_q)
        aerc_pkg::AERC_IDLE: if (req) state_q <= aerc_pkg::AERC_ACK;
        aerc_pkg::AERC_ACK: state_q <= aerc_pkg::AERC_IDLE;
        default: state_q <= aerc_pkg::AERC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event flags. The clear register is a strobe and does not hold its value.
  always_comb
  begin
    clear_d = `AERC_EVT_RESET;
    if (wr_hit && wb_adr_i == `AERC_OFF_EVENT_CLEAR && wb_sel_i[0])
      clear_d = wb_dat_i[6:0];
  end

  aerc_event_flags u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(event_i),
    .clear_i(clear_d),
    .mask_i(mask_q),
    .raw_o(raw),
    .masked_o(masked)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask_q <= `AERC_MASK_RESET;
    else if (wr_hit && wb_adr_i == `AERC_OFF_EVENT_MASK && wb_sel_i[0])
      mask_q <= wb_dat_i[6:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |masked;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Calibration user values.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      user_offset_q <= `AERC_CAL_RESET;
    else if (wr_hit && wb_adr_i == `AERC_OFF_OFFSET_CAL)
    begin
      if (wb_sel_i[2]) user_offset_q[7:0] <= wb_dat_i[23:16];
      if (wb_sel_i[3]) user_offset_q[15:8] <= wb_dat_i[31:24];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      user_gain_q <= `AERC_CAL_RESET;
    else if (wr_hit && wb_adr_i == `AERC_OFF_GAIN_CAL)
    begin
      if (wb_sel_i[2]) user_gain_q[7:0] <= wb_dat_i[23:16];
      if (wb_sel_i[3]) user_gain_q[15:8] <= wb_dat_i[31:24];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Test and audio controls.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      test_q <= '0;
    else if (wr_hit && wb_adr_i == `AERC_OFF_TEST_CTRL && wb_sel_i[0])
    begin
      test_q.en <= wb_dat_i[`AERC_TEST_EN_BIT];
      test_q.sel <= wb_dat_i[`AERC_TEST_SEL_LSB +: `AERC_TEST_SEL_W];
    end
  end

  // Bits 8 and 9 sit in byte lane 1, the rest in lane 0; common mode spans both.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      audio_q.audio_en <= 1'b0;
      audio_q.preamp_gain <= `AERC_GAIN_RESET;
      audio_q.preamp_common_mode <= `AERC_CM_RESET;
      audio_q.chop_en <= `AERC_CHOP_RESET;
    end
    else if (wr_hit && wb_adr_i == `AERC_OFF_AUDIO_CTRL && wb_sel_i[0] && wb_sel_i[1])
    begin
      audio_q.audio_en <= wb_dat_i[`AERC_AUD_EN_BIT];
      audio_q.preamp_gain <= wb_dat_i[`AERC_AUD_GAIN_LSB +: `AERC_AUD_GAIN_W];
      audio_q.preamp_common_mode <= wb_dat_i[`AERC_AUD_CM_LSB +: `AERC_AUD_CM_W];
      audio_q.chop_en <= wb_dat_i[`AERC_AUD_CHOP_BIT];
    end
  end

  aerc_audio_decode u_dec (
    .audio_i(audio_q),
    .test_i(test_q),
    .preamp_gain_value_o(gain_val),
    .test_route_o(route),
    .test_drive_n_o(drive_n)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      audio_en_o <= 1'b0;
      decim_en_o <= 1'b0;
      chop_en_o <= `AERC_CHOP_RESET;
      preamp_common_mode_o <= `AERC_CM_RESET;
      preamp_gain_value_o <= `AERC_GAIN_VAL_RESET;
      test_route_o <= `AERC_ROUTE_RESET;
      test_drive_n_o <= `AERC_DRIVE_N_RESET;
      user_offset_o <= `AERC_CAL_RESET;
      user_gain_o <= `AERC_CAL_RESET;
    end
    else
    begin
      audio_en_o <= audio_q.audio_en;
      decim_en_o <= audio_q.audio_en;
      chop_en_o <= audio_q.chop_en;
      preamp_common_mode_o <= audio_q.preamp_common_mode;
      preamp_gain_value_o <= gain_val;
      test_route_o <= route;
      test_drive_n_o <= drive_n;
      user_offset_o <= user_offset_q;
      user_gain_o <= user_gain_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux. Reserved bits and unmapped addresses read as zero.
  always_comb
  begin
    rd_d = `AERC_ZERO32;
    case (wb_adr_i)
      `AERC_OFF_MASKED_STATUS: rd_d[6:0] = masked;
      `AERC_OFF_EVENT_MASK: rd_d[6:0] = mask_q;
      `AERC_OFF_RAW_STATUS: rd_d[6:0] = raw;
      `AERC_OFF_EVENT_CLEAR: rd_d = `AERC_ZERO32;
      `AERC_OFF_FINAL_RESULT: rd_d = final_result_i;
      `AERC_OFF_UNCAL_RESULT: rd_d[21:0] = raw_result_i;
      `AERC_OFF_OFFSET_CAL: rd_d = {user_offset_q, self_offset_i};
      `AERC_OFF_GAIN_CAL: rd_d = {user_gain_q, self_gain_i};
      `AERC_OFF_TEST_CTRL: rd_d[3:0] = {test_q.sel, test_q.en};
      `AERC_OFF_AUDIO_CTRL:
        rd_d[9:0] = {audio_q.chop_en, audio_q.preamp_common_mode,
                     audio_q.preamp_gain, 2'b00, audio_q.audio_en};
      default: rd_d = `AERC_ZERO32;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= `AERC_ZERO32;
    else if (req && !wb_we_i)
      wb_dat_o <= rd_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack did not follow request");
  irq_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 irq_o == (|$past(masked)))
    else $error("irq does not follow masked status");
  mask_hide_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mask_q[2] && raw[2]) |-> !masked[2])
    else $error("masked flag visible");
  chop_reset_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> (audio_q.chop_en && audio_q.preamp_common_mode == `AERC_CM_RESET))
    else $error("audio reset values wrong");
  test_hiz_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !test_q.en |=> test_drive_n_o)
    else $error("test pin driven while disabled");
  audio_en_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (audio_en_o == $past(audio_q.audio_en)) && (decim_en_o == audio_en_o))
    else $error("audio enable not applied");
  raw_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && wb_adr_i == `AERC_OFF_UNCAL_RESULT) |=>
      (wb_dat_o[31:22] == 10'h000 && wb_dat_o[21:0] == $past(raw_result_i)))
    else $error("raw result read wrong");
  final_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && wb_adr_i == `AERC_OFF_FINAL_RESULT) |=>
      wb_dat_o == $past(final_result_i))
    else $error("final result read wrong");
  cover_read_c: cover property (@(posedge clk_i) req && !wb_we_i ##1 wb_ack_o);
  cover_clear_c: cover property (@(posedge clk_i) |clear_d);
  cover_irq_c: cover property (@(posedge clk_i) $rose(irq_o));
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the converter event, result and control register bank.
`timescale 1ns/100ps
`include "aerc_defs.svh"
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [6:0] event_i = 7'h00;
  logic [31:0] final_result_i = 32'h0000_0000;
  logic [21:0] raw_result_i = 22'h00_0000;
  logic [15:0] self_offset_i = 16'h0000;
  logic [15:0] self_gain_i = 16'h0000;
  logic [15:0] user_offset_o;
  logic [15:0] user_gain_o;
  logic audio_en_o;
  logic decim_en_o;
  logic chop_en_o;
  logic [2:0] preamp_common_mode_o;
  logic [5:0] preamp_gain_value_o;
  logic [7:0] test_route_o;
  logic test_drive_n_o;
  logic irq_o;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] rd;

  aerc_regs i_aerc_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .event_i(event_i),
    .final_result_i(final_result_i),
    .raw_result_i(raw_result_i),
    .self_offset_i(self_offset_i),
    .self_gain_i(self_gain_i),
    .user_offset_o(user_offset_o),
    .user_gain_o(user_gain_o),
    .audio_en_o(audio_en_o),
    .decim_en_o(decim_en_o),
    .chop_en_o(chop_en_o),
    .preamp_common_mode_o(preamp_common_mode_o),
    .preamp_gain_value_o(preamp_gain_value_o),
    .test_route_o(test_route_o),
    .test_drive_n_o(test_drive_n_o),
    .irq_o(irq_o)
  );

  always #2.5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // The whole run needs well under a thousand cycles; a hung handshake ends here.
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      err_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The request stands until ack is seen high at a rising edge; read data is taken there.
  task automatic wb_lanes(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          input logic [3:0] sel);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_lanes(we, adr, dat, 4'hF);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic settle;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic pulse(input logic [6:0] ev);
    @(posedge clk_i);
    event_i <= ev;
    @(posedge clk_i);
    event_i <= 7'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic reset_values;
    rd_chk(`AERC_OFF_RAW_STATUS, 32'h0000_0000);
    rd_chk(`AERC_OFF_EVENT_MASK, 32'h0000_007F);
    rd_chk(`AERC_OFF_AUDIO_CTRL, 32'h0000_0300);
    check({31'h0, chop_en_o}, 32'h0000_0001);
    check({29'h0, preamp_common_mode_o}, 32'h0000_0004);
    check({31'h0, audio_en_o}, 32'h0000_0000);
    check({31'h0, test_drive_n_o}, 32'h0000_0001);
    check({31'h0, irq_o}, 32'h0000_0000);
  endtask

  task automatic events;
    for (int i = 0; i < 7; i++)
    begin
      pulse(7'h01 << i);
      rd_chk(`AERC_OFF_RAW_STATUS, (32'h0000_0002 << i) - 32'h0000_0001);
    end
    check({31'h0, irq_o}, 32'h0000_0000);
    wb(1'b1, `AERC_OFF_EVENT_MASK, 32'h0000_0000);
    settle();
    check({31'h0, irq_o}, 32'h0000_0001);
    rd_chk(`AERC_OFF_MASKED_STATUS, 32'h0000_007F);
    wb(1'b1, `AERC_OFF_EVENT_CLEAR, 32'h0000_0055);
    rd_chk(`AERC_OFF_RAW_STATUS, 32'h0000_002A);
    rd_chk(`AERC_OFF_MASKED_STATUS, 32'h0000_002A);
    wb(1'b1, `AERC_OFF_EVENT_CLEAR, 32'h0000_002A);
    settle();
    check({31'h0, irq_o}, 32'h0000_0000);
    rd_chk(`AERC_OFF_RAW_STATUS, 32'h0000_0000);
    wb(1'b1, `AERC_OFF_EVENT_MASK, 32'h0000_0001);
    pulse(7'h01);
    settle();
    rd_chk(`AERC_OFF_RAW_STATUS, 32'h0000_0001);
    rd_chk(`AERC_OFF_MASKED_STATUS, 32'h0000_0000);
    check({31'h0, irq_o}, 32'h0000_0000);
  endtask

  // An event landing on the edge that takes the clear must survive it.
  task automatic clear_race;
    pulse(7'h04);
    fork
      wb(1'b1, `AERC_OFF_EVENT_CLEAR, 32'h0000_0005);
      pulse(7'h04);
    join
    rd_chk(`AERC_OFF_RAW_STATUS, 32'h0000_0004);
    settle();
    check({31'h0, irq_o}, 32'h0000_0001);
    wb(1'b1, `AERC_OFF_EVENT_CLEAR, 32'h0000_0004);
    rd_chk(`AERC_OFF_RAW_STATUS, 32'h0000_0000);
    settle();
    check({31'h0, irq_o}, 32'h0000_0000);
  endtask

  task automatic results;
    @(posedge clk_i);
    final_result_i <= 32'hA5C3_1E07;
    raw_result_i <= 22'h3F_FFFE;
    self_offset_i <= 16'h8001;
    self_gain_i <= 16'h7FFE;
    wb(1'b1, `AERC_OFF_FINAL_RESULT, 32'h5A5A_5A5A);
    rd_chk(`AERC_OFF_FINAL_RESULT, 32'hA5C3_1E07);
    wb(1'b1, `AERC_OFF_UNCAL_RESULT, 32'h0000_1234);
    rd_chk(`AERC_OFF_UNCAL_RESULT, 32'h003F_FFFE);
    wb(1'b1, `AERC_OFF_OFFSET_CAL, 32'h1234_FFFF);
    rd_chk(`AERC_OFF_OFFSET_CAL, 32'h1234_8001);
    wb(1'b1, `AERC_OFF_GAIN_CAL, 32'hFEDC_0000);
    rd_chk(`AERC_OFF_GAIN_CAL, 32'hFEDC_7FFE);
    check({16'h0, user_offset_o}, 32'h0000_1234);
    check({16'h0, user_gain_o}, 32'h0000_FEDC);
    rd_chk(8'h60, 32'h0000_0000);
  endtask

  task automatic test_path;
    for (int i = 0; i < 8; i++)
    begin
      wb(1'b1, `AERC_OFF_TEST_CTRL, (32'(i) << 1) | 32'h0000_0001);
      settle();
      check({24'h0, test_route_o}, 32'h0000_0001 << i);
      check({31'h0, test_drive_n_o}, 32'h0000_0000);
    end
    wb(1'b1, `AERC_OFF_TEST_CTRL, 32'h0000_000A);
    settle();
    check({31'h0, test_drive_n_o}, 32'h0000_0001);
    check({24'h0, test_route_o}, 32'h0000_0000);
    rd_chk(`AERC_OFF_TEST_CTRL, 32'h0000_000A);
  endtask

  task automatic audio;
    for (int g = 0; g < 4; g++)
    begin
      wb(1'b1, `AERC_OFF_AUDIO_CTRL, (32'(g) << 6) | (32'(g) << 3) | 32'h0000_0001);
      settle();
      check({26'h0, preamp_gain_value_o}, 32'h0000_0004 << g);
      check({30'h0, audio_en_o, decim_en_o}, 32'h0000_0003);
      check({31'h0, chop_en_o}, 32'h0000_0000);
      check({29'h0, preamp_common_mode_o}, 32'(g));
    end
    wb(1'b1, `AERC_OFF_AUDIO_CTRL, 32'h0000_0229);
    settle();
    check({26'h0, preamp_gain_value_o}, 32'h0000_0004);
    wb(1'b1, `AERC_OFF_AUDIO_CTRL, 32'h0000_03C0);
    settle();
    check({30'h0, audio_en_o, decim_en_o}, 32'h0000_0000);
    check({31'h0, chop_en_o}, 32'h0000_0001);
    check({29'h0, preamp_common_mode_o}, 32'h0000_0007);
    rd_chk(`AERC_OFF_AUDIO_CTRL, 32'h0000_03C0);
  endtask

  // A write without both lanes 0 and 1 leaves the audio control as it was; an offset write changes only its enabled lane.
  task automatic lanes;
    wb_lanes(1'b1, `AERC_OFF_AUDIO_CTRL, 32'h0000_0001, 4'h1);
    rd_chk(`AERC_OFF_AUDIO_CTRL, 32'h0000_03C0);
    check({31'h0, audio_en_o}, 32'h0000_0000);
    wb_lanes(1'b1, `AERC_OFF_OFFSET_CAL, 32'hAB00_0000, 4'h8);
    rd_chk(`AERC_OFF_OFFSET_CAL, 32'hAB34_8001);
  endtask

  // A second reset in mid-run must bring the audio, mask, offset calibration and test drive controls back to their reset values.
  task automatic reset_again;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`AERC_OFF_AUDIO_CTRL, 32'h0000_0300);
    rd_chk(`AERC_OFF_EVENT_MASK, 32'h0000_007F);
    rd_chk(`AERC_OFF_OFFSET_CAL, 32'h0000_8001);
    check({16'h0, user_offset_o}, 32'h0000_0000);
    check({29'h0, preamp_common_mode_o}, 32'h0000_0004);
    check({31'h0, chop_en_o}, 32'h0000_0001);
    check({26'h0, preamp_gain_value_o}, 32'h0000_0004);
    check({31'h0, test_drive_n_o}, 32'h0000_0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_values();
    events();
    clear_race();
    results();
    test_path();
    audio();
    lanes();
    reset_again();
    print_verdict();
  end
endmodule
